// >>> option_bits_pkg.sv
package option_bits_pkg;

	// Flash locations of the option and trim bytes
	localparam logic [15:0] USER_OPTION_BYTE_ZERO_ADDR   = 16'h0000;
	localparam logic [15:0] USER_OPTION_BYTE_ONE_ADDR    = 16'h0001;
	localparam logic [15:0] TRIM_PAGE_BASE_ADDR          = 16'h0020;
	localparam logic [15:0] RESERVED_TRIM_BYTE_ZERO_ADDR = 16'h0020;
	localparam logic [15:0] RESERVED_TRIM_BYTE_ONE_ADDR  = 16'h0021;
	localparam logic [15:0] OSCILLATOR_TRIM_BYTE_ADDR    = 16'h0022;
	localparam logic [15:0] VOLTAGE_DETECT_TRIM_BYTE_ADDR = 16'h0023;
	localparam logic [15:0] RESERVED_TRIM_BYTE_FOUR_ADDR = 16'h0024;

	// Trim index space
	localparam int          TRIM_COUNT     = 32;
	localparam logic [4:0]  OSC_TRIM_INDEX = 5'h02;
	localparam logic [4:0]  VOLTAGE_DETECT_TRIM_INDEX = 5'h03;
	localparam logic [7:0]  TRIM_INDEX_MAX = 8'h1f;

	// Option byte zero field positions
	localparam int WDT_RESPONSE_BIT   = 7;
	localparam int WDT_ALWAYS_ON_BIT  = 6;
	localparam int OSC_MODE_HI_BIT    = 5;
	localparam int OSC_MODE_LO_BIT    = 4;
	localparam int BROWNOUT_AO_BIT    = 3;
	localparam int READ_PROTECT_BIT   = 2;
	localparam int WRITE_PROTECT_BIT  = 0;
	// Option byte one field positions
	localparam int CRYSTAL_OFF_BIT    = 4;
	// Voltage detect trim field width
	localparam int VOLTAGE_DETECT_TRIM_WIDTH     = 5;

	// Erased flash reads all ones
	localparam logic [7:0] ERASED_BYTE      = 8'hff;
	localparam logic [7:0] TRIM_INDEX_RESET = 8'h00;

	// Threshold in mV: top value and step per count
	localparam logic [11:0] LVD_TOP_MV  = 12'd3600;
	localparam logic [11:0] LVD_STEP_MV = 12'd50;

	typedef enum logic [1:0] {
		OSC_RC_NETWORK = 2'h0,
		OSC_XTAL_MIN   = 2'h1,
		OSC_XTAL_MED   = 2'h2,
		OSC_XTAL_MAX   = 2'h3
	} osc_drive_mode_t;

	typedef struct packed {
		logic            watchdog_response_select;
		logic            watchdog_always_on;
		osc_drive_mode_t oscillator_drive_mode;
		logic            brownout_always_on;
		logic            code_read_protect;
		logic            code_write_protect;
		logic            crystal_off_in_reset;
	} option_controls_t;

	typedef struct packed {
		logic       req;
		logic [7:0] addr;
	} flash_read_t;

endpackage : option_bits_pkg

// >>> option_loader_seq.sv
`timescale 1ns/1ps
module option_loader_seq
	import option_bits_pkg::*;
(
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        resetn,
	// Reload request
	input  wire logic        reload_req,
	// Flash read port
	output flash_read_t      flash_rd,
	input  wire logic        flash_rd_valid,
	// Progress
	output logic [2:0]       step,
	output logic             step_done,
	output logic             busy
);
	typedef enum logic [1:0] {LD_IDLE, LD_ISSUE, LD_WAIT} ld_state_t;

	ld_state_t  state_q;
	logic [2:0] step_q;

	function automatic logic [7:0] step_addr(input logic [2:0] s);
		unique case (s)
			3'd0:    step_addr = USER_OPTION_BYTE_ZERO_ADDR[7:0];
			3'd1:    step_addr = USER_OPTION_BYTE_ONE_ADDR[7:0];
			3'd2:    step_addr = RESERVED_TRIM_BYTE_ZERO_ADDR[7:0];
			3'd3:    step_addr = RESERVED_TRIM_BYTE_ONE_ADDR[7:0];
			3'd4:    step_addr = OSCILLATOR_TRIM_BYTE_ADDR[7:0];
			3'd5:    step_addr = VOLTAGE_DETECT_TRIM_BYTE_ADDR[7:0];
			default: step_addr = RESERVED_TRIM_BYTE_FOUR_ADDR[7:0];
		endcase
	endfunction : step_addr

	// Starts loading straight out of reset
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= LD_ISSUE;
			step_q  <= 3'd0;
		end else begin
			unique case (state_q)
				LD_IDLE: begin
					if (reload_req) begin
						state_q <= LD_ISSUE;
						step_q  <= 3'd0;
					end
				end
				LD_ISSUE: state_q <= LD_WAIT;
				LD_WAIT: begin
					if (flash_rd_valid) begin
						if (step_q == 3'd6) begin
							state_q <= LD_IDLE;
						end else begin
							state_q <= LD_ISSUE;
							step_q  <= step_q + 3'd1;
						end
					end
				end
			endcase
		end
	end

	assign flash_rd.req  = (state_q == LD_ISSUE);
	assign flash_rd.addr = step_addr(step_q);
	assign step          = step_q;
	assign step_done     = (state_q == LD_WAIT) && flash_rd_valid;
	assign busy          = (state_q != LD_IDLE);

endmodule : option_loader_seq

// >>> flash_option_bit_decoder.sv
// Operation
// [R1] Watchdog response bit 0 gives interrupt on time-out, 1 gives system reset.
// [R2] Watchdog interrupt taken only while interrupts are globally enabled.
// [R3] Always-on bit 0 starts watchdog at power-up and ignores disable attempts.
// [R4] Always-on bit 1: watchdog starts on instruction, stops only on reset/recovery.
// [R5] Two-bit oscillator mode selects RC, min, medium or max crystal drive.
// [R6] Brownout always-on 0: off in STOP only if power control bit requests.
// [R7] Brownout always-on 1: brownout stays enabled always, STOP included.
// [R8] Read-protect 0 blocks user code reads and limits debugger commands.
// [R9] Read-protect 1 allows code access and every debugger command.
// [R10] Write-protect 0 rejects user program/erase; debugger mass erase still allowed.
// [R11] Write-protect 1 permits program, page erase and mass erase everywhere.
// [R12] Crystal-off bit 0 runs crystal during reset, longer; 1 keeps it off.
// [R13] Crystal-off bit only enables the crystal, never switches system clock.
// [R14] Voltage detect threshold is 3.6 V minus 50 mV per trim count.
// [R15] Trim byte at 0022H supplies the working precision oscillator trim.
// [R16] Software should leave reserved trim bytes unchanged.
// [R17] Every reset or stop recovery copies option bits before the CPU runs.
// [R18] Trim index write 00H-1FH selects which byte the next data write changes.
// [R19] Erased option bytes read all ones, giving the erased defaults.
`timescale 1ns/1ps
module flash_option_bit_decoder
	import option_bits_pkg::*;
#(
	parameter int TRIM_BYTES = TRIM_COUNT
) (
	// Clock and reset
	input  wire logic              core_clk,
	input  wire logic              resetn,
	input  wire logic              stop_recovery,
	// Flash read port
	output flash_read_t            flash_rd,
	input  wire logic              flash_rd_valid,
	input  wire logic [7:0]        flash_rd_data,
	// Trim index and value registers
	input  wire logic              trim_index_wr,
	input  wire logic              trim_value_wr,
	input  wire logic              trim_value_rd,
	input  wire logic [7:0]        trim_wdata,
	output logic [7:0]             trim_index_register,
	output logic [7:0]             trim_value_register,
	// Processor hold and option controls
	output logic                   cpu_hold,
	output option_controls_t       controls,
	// Watchdog
	input  wire logic              wdt_timeout,
	input  wire logic              wdt_start_instr,
	input  wire logic              wdt_disable_req,
	input  wire logic              irq_global_enable,
	output logic                   wdt_running,
	output logic                   wdt_irq,
	output logic                   wdt_sys_reset,
	// Brownout
	input  wire logic              in_stop_mode,
	input  wire logic              brownout_off_request,
	output logic                   brownout_enable,
	// Debugger and flash controller
	output logic                   code_read_allowed,
	output logic                   debug_full_access,
	input  wire logic              user_program_req,
	input  wire logic              user_page_erase_req,
	input  wire logic              user_mass_erase_req,
	input  wire logic              debug_mass_erase_req,
	output logic                   program_grant,
	output logic                   page_erase_grant,
	output logic                   mass_erase_grant,
	// Oscillator and voltage detect
	output logic                   crystal_run_in_reset,
	output logic [7:0]             precision_osc_trim,
	output logic [VOLTAGE_DETECT_TRIM_WIDTH-1:0] voltage_detect_trim,
	output logic [11:0]            voltage_detect_threshold
);
	logic [7:0]       opt0_q;
	logic [7:0]       opt1_q;
	logic [7:0]       trim_q [TRIM_BYTES];
	logic [7:0]       index_q;
	logic [7:0]       rdata_q;
	logic             wdt_run_q;
	logic             irq_q;
	logic [2:0]       step;
	logic             step_done;
	logic             busy;

	function automatic logic [11:0] lvd_mv(input logic [VOLTAGE_DETECT_TRIM_WIDTH-1:0] code);
		lvd_mv = LVD_TOP_MV - 12'(LVD_STEP_MV * 12'(code));
	endfunction : lvd_mv

	// Sequencer reads the option bytes, then trim bytes 20H..24H
	option_loader_seq u_loader (
		.core_clk       (core_clk),
		.resetn         (resetn),
		.reload_req     (stop_recovery),
		.flash_rd       (flash_rd),
		.flash_rd_valid (flash_rd_valid),
		.step           (step),
		.step_done      (step_done),
		.busy           (busy)
	);

	// CPU held until all holding registers are loaded
	assign cpu_hold = busy; // [R17]

	// Option holding registers start erased until flash answers
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			opt0_q <= ERASED_BYTE; // [R19]
			opt1_q <= ERASED_BYTE; // [R19]
		end else if (step_done && step == 3'd0) begin
			opt0_q <= flash_rd_data; // [R17]
		end else if (step_done && step == 3'd1) begin
			opt1_q <= flash_rd_data; // [R17]
		end
	end

	// Trim working copies: loaded from flash, rewritten through the index
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < TRIM_BYTES; i++) begin
				trim_q[i] <= ERASED_BYTE;
			end
		end else if (step_done && step >= 3'd2) begin
			trim_q[5'(step - 3'd2)] <= flash_rd_data; // [R17]
		end else if (trim_value_wr && !busy && index_q <= TRIM_INDEX_MAX) begin
			// Reserved bytes are writable too; software must not touch them
			trim_q[index_q[4:0]] <= trim_wdata; // [R18] [R16]
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			index_q <= TRIM_INDEX_RESET;
		end else if (trim_index_wr) begin
			index_q <= trim_wdata; // [R18]
		end
	end

	// Out-of-range index reads back zero
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			rdata_q <= 8'h00;
		end else if (trim_value_rd) begin
			rdata_q <= (index_q <= TRIM_INDEX_MAX) ? trim_q[index_q[4:0]] : 8'h00; // [R18]
		end
	end

	assign trim_index_register = index_q;
	assign trim_value_register = rdata_q;

	always_comb begin
		controls.watchdog_response_select = opt0_q[WDT_RESPONSE_BIT];
		controls.watchdog_always_on       = opt0_q[WDT_ALWAYS_ON_BIT];
		controls.oscillator_drive_mode    =
			osc_drive_mode_t'(opt0_q[OSC_MODE_HI_BIT:OSC_MODE_LO_BIT]); // [R5]
		controls.brownout_always_on       = opt0_q[BROWNOUT_AO_BIT];
		controls.code_read_protect        = opt0_q[READ_PROTECT_BIT];
		controls.code_write_protect       = opt0_q[WRITE_PROTECT_BIT];
		controls.crystal_off_in_reset     = opt1_q[CRYSTAL_OFF_BIT];
	end

	// Watchdog run state; always-on ignores disable requests
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			wdt_run_q <= 1'b0;
		end else if (stop_recovery) begin
			wdt_run_q <= 1'b0; // [R4]
		end else if (!controls.watchdog_always_on) begin
			wdt_run_q <= !busy; // [R3]
		end else if (wdt_start_instr) begin
			wdt_run_q <= 1'b1; // [R4]
		end
	end
	// A disable request has no path here: only reset or recovery stop it
	logic unused_disable;
	assign unused_disable = wdt_disable_req; // [R3]

	// Interrupt pending until acknowledged by global enable
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			irq_q <= 1'b0;
		end else if (wdt_timeout && wdt_run_q && !controls.watchdog_response_select) begin
			irq_q <= 1'b1; // [R1]
		end else if (irq_global_enable) begin
			irq_q <= 1'b0; // [R2]
		end
	end

	assign wdt_running   = wdt_run_q;
	assign wdt_irq       = irq_q && irq_global_enable; // [R2]
	assign wdt_sys_reset = wdt_timeout && wdt_run_q
		&& controls.watchdog_response_select; // [R1]

	assign brownout_enable = controls.brownout_always_on // [R7]
		|| !(in_stop_mode && brownout_off_request); // [R6]

	assign code_read_allowed = controls.code_read_protect; // [R8] [R9]
	assign debug_full_access = controls.code_read_protect; // [R8] [R9]

	// Requests during load are refused so stale protection cannot leak
	assign program_grant    = user_program_req && controls.code_write_protect && !busy; // [R10] [R11]
	assign page_erase_grant = user_page_erase_req && controls.code_write_protect && !busy; // [R10]
	assign mass_erase_grant = !busy && ((user_mass_erase_req && controls.code_write_protect)
		|| debug_mass_erase_req); // [R10] [R11]

	// Crystal enable only; clock source selection stays with software
	assign crystal_run_in_reset = !controls.crystal_off_in_reset; // [R12] [R13]

	assign precision_osc_trim       = trim_q[OSC_TRIM_INDEX]; // [R15]
	assign voltage_detect_trim      = trim_q[VOLTAGE_DETECT_TRIM_INDEX][VOLTAGE_DETECT_TRIM_WIDTH-1:0];
	assign voltage_detect_threshold = lvd_mv(voltage_detect_trim); // [R14]

endmodule : flash_option_bit_decoder

// >>> option_checker_assertions.sv
`timescale 1ns/1ps
module option_checker
	import option_bits_pkg::*;
(
	// Clock and reset
	input wire logic                      core_clk,
	input wire logic                      resetn,
	input wire logic                      stop_recovery,
	// Watched controls
	input wire logic                      cpu_hold,
	input wire option_controls_t          controls,
	input wire logic                      irq_global_enable,
	input wire logic                      wdt_running,
	input wire logic                      wdt_irq,
	input wire logic                      wdt_sys_reset,
	input wire logic                      in_stop_mode,
	input wire logic                      brownout_off_request,
	input wire logic                      brownout_enable,
	input wire logic                      code_read_allowed,
	input wire logic                      debug_full_access,
	input wire logic                      program_grant,
	input wire logic                      page_erase_grant,
	input wire logic                      crystal_run_in_reset,
	input wire logic [VOLTAGE_DETECT_TRIM_WIDTH-1:0] voltage_detect_trim,
	input wire logic [11:0]               voltage_detect_threshold
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);
	property p_wdt_irq_mode;
		!controls.watchdog_response_select |-> !wdt_sys_reset;
	endproperty
	a_wdt_irq_mode: assert property (p_wdt_irq_mode) else $error("reset in irq mode");
	property p_irq_gate;
		wdt_irq |-> irq_global_enable;
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("irq while disabled");
	// Two settled cycles give the watchdog time to start after loading
	property p_wdt_forced;
		!controls.watchdog_always_on && !cpu_hold && !$past(cpu_hold) && !$past(cpu_hold, 2)
			|-> wdt_running;
	endproperty
	a_wdt_forced: assert property (p_wdt_forced) else $error("watchdog not forced on");
	property p_bo_on;
		controls.brownout_always_on |-> brownout_enable;
	endproperty
	a_bo_on: assert property (p_bo_on) else $error("brownout dropped");
	property p_bo_off;
		!controls.brownout_always_on && in_stop_mode && brownout_off_request |-> !brownout_enable;
	endproperty
	a_bo_off: assert property (p_bo_off) else $error("brownout not off in stop");
	property p_read_prot;
		code_read_allowed == controls.code_read_protect
			&& debug_full_access == controls.code_read_protect;
	endproperty
	a_read_prot: assert property (p_read_prot) else $error("read protect mismatch");
	property p_write_prot;
		!controls.code_write_protect |-> !program_grant && !page_erase_grant;
	endproperty
	a_write_prot: assert property (p_write_prot) else $error("grant while protected");
	property p_xtal;
		crystal_run_in_reset == !controls.crystal_off_in_reset;
	endproperty
	a_xtal: assert property (p_xtal) else $error("crystal state mismatch");
	property p_lvd;
		voltage_detect_threshold == 12'he10 - 12'h032 * {7'h00, voltage_detect_trim};
	endproperty
	a_lvd: assert property (p_lvd) else $error("threshold mismatch");
	property p_reload;
		stop_recovery |-> ##[1:2] cpu_hold;
	endproperty
	a_reload: assert property (p_reload) else $error("no reload on recovery");
endmodule : option_checker
bind flash_option_bit_decoder option_checker u_option_checker (.core_clk, .resetn,
	.stop_recovery, .cpu_hold, .controls, .irq_global_enable, .wdt_running, .wdt_irq,
	.wdt_sys_reset, .in_stop_mode, .brownout_off_request, .brownout_enable,
	.code_read_allowed, .debug_full_access, .program_grant, .page_erase_grant,
	.crystal_run_in_reset, .voltage_detect_trim, .voltage_detect_threshold);

// >>> flash_model.sv
`timescale 1ns/1ps
module flash_model
	import option_bits_pkg::*;
(
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        resetn,
	// Read port
	input  wire flash_read_t flash_rd,
	output logic             flash_rd_valid,
	output logic [7:0]       flash_rd_data,
	// Stored bytes and answer delay
	input  wire logic [7:0]  opt0,
	input  wire logic [7:0]  opt1,
	input  wire logic [7:0]  osc_b,
	input  wire logic [7:0]  lvd_b,
	input  wire logic [3:0]  lat
);
	logic [7:0] addr_q;
	logic [3:0] cnt_q;
	logic [7:0] d;
	always_comb begin
		case (addr_q)
			8'h00: d = opt0;
			8'h01: d = opt1;
			8'h22: d = osc_b;
			8'h23: d = lvd_b;
			default: d = ERASED_BYTE;
		endcase
	end
	// Off the valid cycle the bus shows the inverse so stale data cannot pass
	assign flash_rd_data = flash_rd_valid ? d : ~d;
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			flash_rd_valid <= 1'b0;
			cnt_q <= 4'h0;
			addr_q <= 8'h00;
		end else begin
			flash_rd_valid <= 1'b0;
			if (flash_rd.req) begin
				addr_q <= flash_rd.addr;
				cnt_q <= lat;
			end else if (cnt_q != 4'h0) begin
				cnt_q <= cnt_q - 4'h1;
				flash_rd_valid <= (cnt_q == 4'h1);
			end
		end
	end
endmodule : flash_model

// >>> tb_top.sv
`timescale 1ns/1ps
module tb_top
	import option_bits_pkg::*;
;
	logic core_clk, resetn, stop_recovery, flash_rd_valid, cpu_hold;
	flash_read_t flash_rd;
	logic [7:0] flash_rd_data, trim_wdata, trim_index_register, trim_value_register;
	logic [7:0] opt0, opt1, osc_b, lvd_b, precision_osc_trim;
	logic [3:0] lat;
	logic trim_index_wr, trim_value_wr, trim_value_rd, wdt_timeout, wdt_start_instr;
	logic wdt_disable_req, irq_global_enable, wdt_running, wdt_irq, wdt_sys_reset;
	logic in_stop_mode, brownout_off_request, brownout_enable, code_read_allowed;
	logic debug_full_access, user_program_req, user_page_erase_req, user_mass_erase_req;
	logic debug_mass_erase_req, program_grant, page_erase_grant, mass_erase_grant;
	logic crystal_run_in_reset;
	logic [4:0] voltage_detect_trim;
	logic [11:0] voltage_detect_threshold;
	option_controls_t controls;
	int failures, total_checks, cycles;
	flash_option_bit_decoder u_flash_option_bit_decoder (.*);
	flash_model u_flash_model (.*);
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	task automatic results();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : results
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			results();
		end
	end
	task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic tick();
		@(negedge core_clk);
		#1;
	endtask : tick
	task automatic reload(input logic [7:0] b0, b1, t2, t3);
		int n;
		n = 0;
		{opt0, opt1, osc_b, lvd_b} = {b0, b1, t2, t3};
		stop_recovery = 1'b1;
		@(negedge core_clk);
		stop_recovery = 1'b0;
		tick();
		chk("cpu_hold", 12'h1, {11'h0, cpu_hold});
		while (cpu_hold !== 1'b0 && n < 300) begin
			tick();
			n++;
		end
		chk("cpu_hold", 12'h0, {11'h0, cpu_hold});
	endtask : reload
	// Only indices 2 and 3 are touched; reserved trims stay as loaded
	task automatic trim_op(input logic [2:0] op, input logic [7:0] d);
		{trim_index_wr, trim_value_wr, trim_value_rd} = op;
		trim_wdata = d;
		tick();
	endtask : trim_op
	task automatic t_erased();
		chk("controls", 12'hff, {4'h0, controls});
		chk("threshold", 12'h802, voltage_detect_threshold);
		chk("xtal", 12'h0, {11'h0, crystal_run_in_reset});
		chk("debug", 12'h3, {10'h0, code_read_allowed, debug_full_access});
		{in_stop_mode, brownout_off_request, user_program_req, user_page_erase_req} = 4'hf;
		tick();
		chk("brownout", 12'h1, {11'h0, brownout_enable});
		chk("grants", 12'h3, {10'h0, program_grant, page_erase_grant});
		chk("wdt idle", 12'h0, {11'h0, wdt_running});
		wdt_start_instr = 1'b1;
		tick();
		wdt_start_instr = 1'b0;
		wdt_timeout = 1'b1;
		#1;
		chk("wdt start", 12'h1, {11'h0, wdt_running});
		chk("sys reset", 12'h1, {11'h0, wdt_sys_reset});
		tick();
		wdt_timeout = 1'b0;
		reload(8'hff, 8'hff, 8'hff, 8'hff);
		chk("wdt stop", 12'h0, {11'h0, wdt_running});
		$display("test erased done");
	endtask : t_erased
	task automatic t_prog();
		lat = 4'h3;
		reload(8'h12, 8'hef, 8'h5c, 8'h0a);
		chk("controls", 12'h10, {4'h0, controls});
		chk("threshold", 12'hc1c, voltage_detect_threshold);
		chk("osc trim", 12'h5c, {4'h0, precision_osc_trim});
		chk("debug", 12'h0, {10'h0, code_read_allowed, debug_full_access});
		chk("xtal", 12'h1, {11'h0, crystal_run_in_reset});
		// Run flop follows the end of loading one cycle later
		tick();
		chk("wdt on", 12'h1, {11'h0, wdt_running});
		chk("brownout", 12'h0, {11'h0, brownout_enable});
		user_mass_erase_req = 1'b1;
		chk("grants", 12'h0, {9'h0, program_grant, page_erase_grant, mass_erase_grant});
		{wdt_disable_req, debug_mass_erase_req, brownout_off_request, wdt_timeout} = 4'hd;
		tick();
		{wdt_disable_req, wdt_timeout} = 2'h0;
		chk("dbg erase", 12'h1, {11'h0, mass_erase_grant});
		chk("brownout", 12'h1, {11'h0, brownout_enable});
		chk("wdt kept", 12'h1, {11'h0, wdt_running});
		chk("irq held", 12'h0, {10'h0, wdt_irq, wdt_sys_reset});
		irq_global_enable = 1'b1;
		#1;
		chk("irq", 12'h1, {11'h0, wdt_irq});
		tick();
		irq_global_enable = 1'b0;
		$display("test programmed done");
	endtask : t_prog
	task automatic t_trim();
		trim_op(3'h4, 8'h02);
		trim_op(3'h2, 8'h33);
		trim_op(3'h1, 8'h00);
		trim_op(3'h4, 8'h03);
		chk("osc trim", 12'h33, {4'h0, precision_osc_trim});
		chk("trim read", 12'h33, {4'h0, trim_value_register});
		trim_op(3'h2, 8'h04);
		trim_op(3'h0, 8'h00);
		chk("trim index", 12'h03, {4'h0, trim_index_register});
		chk("threshold", 12'hd48, voltage_detect_threshold);
		chk("voltage_detect_trim", 12'h04, {7'h0, voltage_detect_trim});
		// Index 22h aliases slot 2 in its low bits, so a missed range check shows up
		trim_op(3'h4, 8'h22);
		trim_op(3'h3, 8'h77);
		trim_op(3'h0, 8'h00);
		chk("osc trim", 12'h33, {4'h0, precision_osc_trim});
		chk("trim read", 12'h00, {4'h0, trim_value_register});
		$display("test trim done");
	endtask : t_trim
	task automatic t_osc();
		for (int m = 0; m < 4; m++) begin
			reload({2'h3, 2'(m), 4'hf}, 8'hff, 8'hff, 8'hff);
			chk("osc mode", 12'(m), {10'h0, controls.oscillator_drive_mode});
		end
		$display("test osc done");
	endtask : t_osc
	initial begin
		{resetn, stop_recovery, trim_index_wr, trim_value_wr, trim_value_rd} = 5'h0;
		{wdt_timeout, wdt_start_instr, wdt_disable_req, irq_global_enable} = 4'h0;
		{in_stop_mode, brownout_off_request, user_program_req, user_page_erase_req} = 4'h0;
		{user_mass_erase_req, debug_mass_erase_req} = 2'h0;
		{opt0, opt1, osc_b, lvd_b, trim_wdata} = {32'hffffffff, 8'h00};
		lat = 4'h1;
		cycles = 0;
		repeat (20) @(posedge core_clk);
		@(negedge core_clk);
		resetn = 1'b1;
		repeat (40) tick();
		t_erased();
		t_prog();
		t_trim();
		t_osc();
		results();
	end
endmodule : tb_top
